// ### hw/srs_pkg.sv
package srs_pkg;
  // ==========================================================================
  // Register indices on the plain parameter port.
  localparam logic [3:0] SRS_REG_SOURCE = 4'h0;
  localparam logic [3:0] SRS_REG_PRESET_INDEX = 4'h1;
  localparam logic [3:0] SRS_REG_AUTOSETUP_INHIBIT = 4'h2;
  localparam logic [3:0] SRS_REG_SCAN_INTERVAL = 4'h3;
  localparam logic [3:0] SRS_REG_STATUS = 4'h4;
  localparam logic [3:0] SRS_REG_DEST = 4'h5;
  localparam logic [3:0] SRS_REG_DRIVE_STATE = 4'h6;
  localparam logic [3:0] SRS_REG_PRESET_BASE = 4'h8;

  // ==========================================================================
  // Reset values.
  localparam logic [2:0] SRS_SOURCE_RESET = 3'h0;
  localparam logic [3:0] SRS_PRESET_INDEX_RESET = 4'h0;
  localparam logic SRS_INHIBIT_RESET = 1'b0;
  localparam logic [15:0] SRS_SCAN_INTERVAL_RESET = 16'h000a;

  // ==========================================================================
  // Scan interval unit: one millisecond at 100 MHz.
  localparam int SRS_CLK_MHZ = 100;
  localparam int SRS_TICK_US = 1000;
  localparam int SRS_TICK_CYCLES = SRS_TICK_US * SRS_CLK_MHZ;

  // ==========================================================================
  // Source selector encodings, then the preset index code that selects scan.
  localparam logic [2:0] SRS_SRC_TWO_ANALOG = 3'h0;
  localparam logic [2:0] SRS_SRC_AN1_PRESET = 3'h1;
  localparam logic [2:0] SRS_SRC_AN2_PRESET = 3'h2;
  localparam logic [2:0] SRS_SRC_PRESET_ONLY = 3'h3;
  localparam logic [2:0] SRS_SRC_KEYPAD = 3'h4;
  localparam logic [2:0] SRS_SRC_PRECISION = 3'h5;
  localparam logic [3:0] SRS_PRESET_SCAN = 4'h9;

  // Active reference channel codes shown on ref_sel.
  localparam logic [3:0] SRS_REF_AN1 = 4'h0;
  localparam logic [3:0] SRS_REF_AN2 = 4'h9;
  localparam logic [3:0] SRS_REF_KEYPAD = 4'ha;
  localparam logic [3:0] SRS_REF_PRECISION = 4'hb;

  // Terminal destination codes.
  localparam logic [2:0] SRS_DEST_NONE = 3'h0;
  localparam logic [2:0] SRS_DEST_LOCAL_REMOTE = 3'h1;
  localparam logic [2:0] SRS_DEST_PRESET_BIT0 = 3'h2;
  localparam logic [2:0] SRS_DEST_PRESET_BIT1 = 3'h3;
  localparam logic [2:0] SRS_DEST_JOG_FWD = 3'h4;

  // Drive state codes; jog is allowed in every state except SRS_DRV_RUN.
  localparam logic [1:0] SRS_DRV_READY = 2'h0;
  localparam logic [1:0] SRS_DRV_INHIBIT = 2'h1;
  localparam logic [1:0] SRS_DRV_TRIP = 2'h2;
  localparam logic [1:0] SRS_DRV_RUN = 2'h3;
endpackage : srs_pkg

// ### hw/srs_preset_mem.sv
`timescale 1ns/100ps
// Eight preset references with one write port and two registered read ports.
module srs_preset_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic we, // Write enable.
  input wire logic [2:0] waddr, // Write slot.
  input wire logic [WIDTH-1:0] wdata, // Write data.
  input wire logic [2:0] raddr_a, // Read slot for the selector.
  output logic [WIDTH-1:0] rdata_a, // Registered selector data.
  input wire logic [2:0] raddr_b, // Read slot for software.
  output logic [WIDTH-1:0] rdata_b // Registered software data.
);
  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================================
  // Storage has no reset; software loads presets before use.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule : srs_preset_mem

// ### hw/srs_selector.sv
`timescale 1ns/100ps
module srs_selector import srs_pkg::*; #(
  parameter int REF_W = 16,
  parameter int TICK_CYCLES = SRS_TICK_CYCLES
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic drive_reset, // Drive reset pulse.
  input wire logic [3:0] addr, // Register index.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [15:0] rdata, // Read data, cycle after rd.
  input wire logic first_digital_input, // First terminal state.
  input wire logic second_digital_input, // Second terminal state.
  input wire logic [REF_W-1:0] analog_one, // Analog input 1 value.
  input wire logic [REF_W-1:0] analog_two, // Analog input 2 value.
  input wire logic [REF_W-1:0] keypad_ref, // Keypad reference value.
  input wire logic [REF_W-1:0] precision_ref, // Precision reference.
  output logic [REF_W-1:0] speed_ref, // Active speed reference.
  output logic [3:0] ref_sel, // Active channel code.
  output logic [2:0] active_source_indicator, // Source in use.
  output logic [3:0] active_preset_indicator, // Preset in use.
  output logic jog_forward, // Jog forward request.
  output logic keypad_sequencer // Keypad drives the sequencer.
);
  logic [2:0] src, next_src;
  logic [3:0] pidx, next_pidx;
  logic inhibit, next_inhibit;
  logic [15:0] scan_int, next_scan_int;
  logic [2:0] dest1, next_dest1, dest2, next_dest2;
  logic [1:0] drv_state, next_drv_state;
  logic [15:0] next_rdata;
  logic [REF_W-1:0] preset_data;
  logic [2:0] rd_slot;

  // Scan state.
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [15:0] ms_cnt, next_ms_cnt;
  logic [2:0] scan_pos, next_scan_pos;

  // Selection outputs.
  logic [3:0] sel, next_sel;
  logic [2:0] next_asi;
  logic [3:0] next_api;
  logic next_jog, next_keyseq;
  logic [REF_W-1:0] next_speed;
  logic [2:0] preset_slot;

  // ==========================================================================
  // Auto destination for each terminal given a source code.
  function automatic logic [5:0] auto_dest(input logic [2:0] s);
    unique case (s)
      SRS_SRC_TWO_ANALOG: auto_dest = {SRS_DEST_LOCAL_REMOTE, SRS_DEST_JOG_FWD};
      SRS_SRC_AN1_PRESET, SRS_SRC_AN2_PRESET, SRS_SRC_PRESET_ONLY:
        auto_dest = {SRS_DEST_PRESET_BIT0, SRS_DEST_PRESET_BIT1};
      default: auto_dest = {SRS_DEST_NONE, SRS_DEST_NONE};
    endcase
  endfunction : auto_dest

  // Channel code for preset number n (1 to 8).
  function automatic logic [3:0] preset_code(input logic [3:0] n);
    preset_code = n;
  endfunction : preset_code

  // The software read port is left open: presets are write-only on the
  // bus, since a readback mux would put logic after the rdata flop.
  srs_preset_mem #(.WIDTH(REF_W), .DEPTH(8)) u_mem (
    .clk(clk),
    .we(wr && addr >= SRS_REG_PRESET_BASE),
    .waddr(addr[2:0]),
    .wdata(wdata[REF_W-1:0]),
    .raddr_a(preset_slot),
    .rdata_a(preset_data),
    .raddr_b(rd_slot),
    .rdata_b()
  );

  assign rd_slot = addr[2:0];

  // ==========================================================================
  // Register writes and reads.
  always_comb begin
    next_src = src;
    next_pidx = pidx;
    next_inhibit = inhibit;
    next_scan_int = scan_int;
    next_dest1 = dest1;
    next_dest2 = dest2;
    next_drv_state = drv_state;
    next_rdata = 16'h0000;
    if (wr) begin
      unique case (addr)
        SRS_REG_SOURCE: if (wdata[2:0] <= SRS_SRC_PRECISION) begin
          next_src = wdata[2:0];
        end
        SRS_REG_PRESET_INDEX: if (wdata[3:0] <= SRS_PRESET_SCAN) begin
          next_pidx = wdata[3:0];
        end
        SRS_REG_AUTOSETUP_INHIBIT: next_inhibit = wdata[0];
        SRS_REG_SCAN_INTERVAL: next_scan_int = wdata;
        SRS_REG_DEST: if (inhibit) begin
          next_dest1 = wdata[2:0];
          next_dest2 = wdata[6:4];
        end
        SRS_REG_DRIVE_STATE: next_drv_state = wdata[1:0];
        default: ;
      endcase
    end
    // Auto set-up is latched only at a drive reset, so a source change
    // never retargets the terminals under a running drive.
    if (drive_reset && !inhibit) begin
      {next_dest1, next_dest2} = auto_dest(src);
    end
    if (rd) begin
      unique case (addr)
        SRS_REG_SOURCE: next_rdata = {13'h0000, src};
        SRS_REG_PRESET_INDEX: next_rdata = {12'h000, pidx};
        SRS_REG_AUTOSETUP_INHIBIT: next_rdata = {15'h0000, inhibit};
        SRS_REG_SCAN_INTERVAL: next_rdata = scan_int;
        SRS_REG_STATUS: next_rdata = {9'h000, active_source_indicator,
                                      active_preset_indicator};
        SRS_REG_DEST: next_rdata = {9'h000, dest2, 1'b0, dest1};
        SRS_REG_DRIVE_STATE: next_rdata = {14'h0000, drv_state};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src <= SRS_SOURCE_RESET;
      pidx <= SRS_PRESET_INDEX_RESET;
      inhibit <= SRS_INHIBIT_RESET;
      scan_int <= SRS_SCAN_INTERVAL_RESET;
      dest1 <= SRS_DEST_LOCAL_REMOTE;
      dest2 <= SRS_DEST_JOG_FWD;
      drv_state <= SRS_DRV_READY;
      rdata <= 16'h0000;
    end else begin
      src <= next_src;
      pidx <= next_pidx;
      inhibit <= next_inhibit;
      scan_int <= next_scan_int;
      dest1 <= next_dest1;
      dest2 <= next_dest2;
      drv_state <= next_drv_state;
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Scan timer: a millisecond tick counted up to the scan interval.
  always_comb begin
    next_tick_cnt = tick_cnt;
    next_ms_cnt = ms_cnt;
    next_scan_pos = scan_pos;
    if (pidx != SRS_PRESET_SCAN) begin
      next_tick_cnt = 32'h0000_0000;
      next_ms_cnt = 16'h0000;
      next_scan_pos = 3'h0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'h0000_0000;
      if (ms_cnt + 16'h0001 >= scan_int) begin
        next_ms_cnt = 16'h0000;
        next_scan_pos = scan_pos + 3'h1;
      end else begin
        next_ms_cnt = ms_cnt + 16'h0001;
      end
    end else begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      ms_cnt <= 16'h0000;
      scan_pos <= 3'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ms_cnt <= next_ms_cnt;
      scan_pos <= next_scan_pos;
    end
  end

  // ==========================================================================
  // Reference selection. Terminal roles come from the destination
  // registers, which move only at a drive reset or a DEST write while inhibit is set, not at a source write.
  always_comb begin
    logic t1;
    logic t2;
    logic [1:0] code;
    t1 = first_digital_input;
    t2 = second_digital_input;
    code = {t2 && dest2 == SRS_DEST_PRESET_BIT1,
            t1 && dest1 == SRS_DEST_PRESET_BIT0};
    next_sel = SRS_REF_AN1;
    next_asi = src;
    next_jog = 1'b0;
    next_keyseq = 1'b0;
    unique case (src)
      SRS_SRC_TWO_ANALOG: begin
        if (pidx <= 4'h1 || pidx == SRS_PRESET_SCAN) begin
          next_sel = (t1 && dest1 == SRS_DEST_LOCAL_REMOTE) ?
                     SRS_REF_AN2 : SRS_REF_AN1;
        end else begin
          next_sel = preset_code(pidx);
        end
        next_jog = t2 && dest2 == SRS_DEST_JOG_FWD &&
                   drv_state != SRS_DRV_RUN;
        next_asi = (t1 && dest1 == SRS_DEST_LOCAL_REMOTE) ?
                   SRS_SRC_AN2_PRESET : SRS_SRC_AN1_PRESET;
      end
      SRS_SRC_AN1_PRESET, SRS_SRC_AN2_PRESET: begin
        if (pidx == 4'h0) begin
          next_sel = (code == 2'h0) ? SRS_REF_AN1 :
                     {2'b00, code} + 4'h1;
        end else if (pidx >= 4'h2 && pidx <= 4'h8) begin
          next_sel = preset_code(pidx);
        end
        if (src == SRS_SRC_AN2_PRESET && next_sel == SRS_REF_AN1) begin
          next_sel = SRS_REF_AN2;
        end
      end
      SRS_SRC_PRESET_ONLY: begin
        if (pidx == 4'h0) begin
          next_sel = {2'b00, code} + 4'h1;
        end else if (pidx <= 4'h8) begin
          next_sel = preset_code(pidx);
        end else begin
          next_sel = 4'h1;
        end
      end
      SRS_SRC_KEYPAD: begin
        next_sel = SRS_REF_KEYPAD;
        next_keyseq = 1'b1;
      end
      SRS_SRC_PRECISION: next_sel = SRS_REF_PRECISION;
      default: next_sel = SRS_REF_AN1;
    endcase
    // Scan walks position 0 as the base channel, then presets 2 to 8.
    if (pidx == SRS_PRESET_SCAN && src != SRS_SRC_KEYPAD &&
        src != SRS_SRC_PRECISION && src != SRS_SRC_TWO_ANALOG) begin
      if (scan_pos == 3'h0) begin
        next_sel = (src == SRS_SRC_PRESET_ONLY) ? 4'h1 :
                   (src == SRS_SRC_AN2_PRESET) ? SRS_REF_AN2 : SRS_REF_AN1;
      end else begin
        next_sel = 4'({1'b0, scan_pos} + 4'h1);
      end
    end else if (pidx == SRS_PRESET_SCAN && src == SRS_SRC_TWO_ANALOG &&
                 scan_pos != 3'h0) begin
      next_sel = 4'({1'b0, scan_pos} + 4'h1);
    end
    next_api = (next_sel >= 4'h1 && next_sel <= 4'h8) ? next_sel :
               (next_sel == SRS_REF_AN1 || next_sel == SRS_REF_AN2) ?
               4'h1 : 4'h0;
  end

  // Preset slot is the channel code minus one.
  assign preset_slot = 3'(next_sel - 4'h1);

  // Memory read is registered, so the muxed reference lands one cycle
  // after the selector settles.
  always_comb begin
    unique case (sel)
      SRS_REF_AN1: next_speed = analog_one;
      SRS_REF_AN2: next_speed = analog_two;
      SRS_REF_KEYPAD: next_speed = keypad_ref;
      SRS_REF_PRECISION: next_speed = precision_ref;
      default: next_speed = preset_data;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= SRS_REF_AN1;
      speed_ref <= '0;
      ref_sel <= SRS_REF_AN1;
      active_source_indicator <= SRS_SOURCE_RESET;
      active_preset_indicator <= 4'h1;
      jog_forward <= 1'b0;
      keypad_sequencer <= 1'b0;
    end else begin
      sel <= next_sel;
      speed_ref <= next_speed;
      ref_sel <= sel;
      active_source_indicator <= next_asi;
      active_preset_indicator <= next_api;
      jog_forward <= next_jog;
      keypad_sequencer <= next_keyseq;
    end
  end
endmodule : srs_selector

// ### verif/srs_operator.sv
`timescale 1ns/100ps
// ==========================================================
// Operator side: terminal switches and reference sources.
module srs_operator (
  input wire logic clk, // System clock.
  output logic first_digital_input, // First terminal level.
  output logic second_digital_input, // Second terminal level.
  output logic [15:0] analog_one, // Analog input 1 level.
  output logic [15:0] analog_two, // Analog input 2 level.
  output logic [15:0] keypad_ref, // Keypad value.
  output logic [15:0] precision_ref // Precision value.
);
  // Distinct steady values, so a wrong pick shows as a wrong number.
  assign analog_one = 16'h1111;
  assign analog_two = 16'h2222;
  assign keypad_ref = 16'h3333;
  assign precision_ref = 16'h4444;

  // Both switches start open.
  initial begin
    first_digital_input = 1'b0;
    second_digital_input = 1'b0;
  end

  // Switches move just after an edge, like a debounced contact.
  task automatic set_pins(input logic t1, input logic t2);
    @(posedge clk);
    first_digital_input <= t1;
    second_digital_input <= t2;
  endtask : set_pins
endmodule : srs_operator

// ### verif/srs_selector_chk.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the speed reference selector.
module srs_selector_chk import srs_pkg::*; #(
  parameter int REF_W = 16
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic [3:0] addr, // Register index.
  input wire logic rd, // Read strobe.
  input wire logic [15:0] rdata, // Read data.
  input wire logic second_digital_input, // Second terminal.
  input wire logic [REF_W-1:0] analog_one, // Analog 1.
  input wire logic [REF_W-1:0] analog_two, // Analog 2.
  input wire logic [REF_W-1:0] keypad_ref, // Keypad value.
  input wire logic [REF_W-1:0] precision_ref, // Precision value.
  input wire logic [REF_W-1:0] speed_ref, // Active reference.
  input wire logic [3:0] ref_sel, // Channel code.
  input wire logic [2:0] active_source_indicator, // Source in use.
  input wire logic [3:0] active_preset_indicator, // Preset in use.
  input wire logic jog_forward, // Jog request.
  input wire logic keypad_sequencer // Keypad sequencing.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Read data stay zero except in the slot after a read strobe.
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  // Status readback carries the indicators of the strobe cycle.
  a_status_read: assert property ($past(rd) &&
    $past(addr) == SRS_REG_STATUS |-> rdata == {9'h000,
    $past(active_source_indicator), $past(active_preset_indicator)})
    else $error("status readback wrong");
  // Settled channel picks must route the matching input; six cycles
  // cover the documented lag of the reference path.
  a_an1_path: assert property (ref_sel == SRS_REF_AN1 [*6]
    |-> speed_ref == analog_one) else $error("analog 1 not routed");
  a_an2_path: assert property (ref_sel == SRS_REF_AN2 [*6]
    |-> speed_ref == analog_two) else $error("analog 2 not routed");
  a_keypad_path: assert property ((ref_sel == SRS_REF_KEYPAD
    && $stable(keypad_ref)) [*6] |-> speed_ref == keypad_ref)
    else $error("keypad value not routed");
  a_prec_path: assert property ((ref_sel == SRS_REF_PRECISION
    && $stable(precision_ref)) [*6] |-> speed_ref == precision_ref)
    else $error("precision value not routed");
  // Keypad source owns the sequencer and never grants jog.
  a_keypad_seq: assert property (
    active_source_indicator == SRS_SRC_KEYPAD [*3]
    |-> keypad_sequencer && !jog_forward)
    else $error("keypad sequencing wrong");
  // Jog cannot stand without the second terminal pressed.
  a_jog_pin: assert property (!second_digital_input [*3]
    |-> !jog_forward) else $error("jog without terminal");
  // Codes stay inside their documented sets.
  a_code_range: assert property (ref_sel <= SRS_REF_PRECISION &&
    active_source_indicator <= SRS_SRC_PRECISION)
    else $error("code out of range");
endmodule : srs_selector_chk

bind srs_selector srs_selector_chk #(.REF_W(REF_W)) chk_u (
  .clk, .rst, .addr, .rd, .rdata, .second_digital_input, .analog_one,
  .analog_two, .keypad_ref, .precision_ref, .speed_ref, .ref_sel,
  .active_source_indicator, .active_preset_indicator, .jog_forward,
  .keypad_sequencer);

// ### verif/srs_selector_test.sv
`timescale 1ns/100ps
// ==========================================================
// Register-level tests of the speed reference selector.
module srs_selector_test import srs_pkg::*; ();
  localparam int TICK = 4;
  localparam int SCAN = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic drive_reset = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, speed_ref, analog_one, analog_two;
  logic [15:0] keypad_ref, precision_ref;
  logic [3:0] ref_sel, active_preset_indicator;
  logic [2:0] active_source_indicator;
  logic first_digital_input, second_digital_input;
  logic jog_forward, keypad_sequencer;
  int err_total = 0;
  int checked = 0;

  // Short scan tick keeps each step of the scan test to eight cycles.
  srs_selector #(.TICK_CYCLES(TICK)) dut_u (.clk, .rst, .drive_reset,
    .addr, .wdata, .wr, .rd, .rdata, .first_digital_input,
    .second_digital_input, .analog_one, .analog_two, .keypad_ref,
    .precision_ref, .speed_ref, .ref_sel, .active_source_indicator,
    .active_preset_indicator, .jog_forward, .keypad_sequencer);
  srs_operator op_u (.clk, .first_digital_input, .second_digital_input,
    .analog_one, .analog_two, .keypad_ref, .precision_ref);

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // ==========================================================
  // Bus and compare helpers.
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data are looked at only in the slot after the strobe.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("register", rdata, exp);
  endtask : rd_chk

  task automatic pulse_reset();
    @(posedge clk);
    drive_reset <= 1'b1;
    @(posedge clk);
    drive_reset <= 1'b0;
  endtask : pulse_reset

  function automatic logic [15:0] ref_val(input logic [3:0] sel);
    case (sel)
      4'h0: return 16'h1111;
      4'h9: return 16'h2222;
      4'ha: return 16'h3333;
      4'hb: return 16'h4444;
      default: return 16'h0a00 + 16'(sel);
    endcase
  endfunction : ref_val

  // Six cycles cover the write-to-reference latency.
  task automatic chk_sel(input logic [3:0] sel);
    repeat (6) @(posedge clk);
    #1;
    check("ref_sel", 16'(ref_sel), 16'(sel));
    check("speed_ref", speed_ref, ref_val(sel));
  endtask : chk_sel

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog: the whole sequence needs under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    stop_test();
  end

  // ==========================================================
  // Test sequence.
  initial begin
    int w;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(SRS_REG_SOURCE, 16'h0000);
    rd_chk(SRS_REG_PRESET_INDEX, 16'h0000);
    rd_chk(SRS_REG_AUTOSETUP_INHIBIT, 16'h0000);
    rd_chk(SRS_REG_SCAN_INTERVAL, SRS_SCAN_INTERVAL_RESET);
    rd_chk(SRS_REG_DEST, 16'h0041);
    chk_sel(SRS_REF_AN1);
    rd_chk(SRS_REG_STATUS, 16'h0011);
    $display("test reset done");
    for (int n = 1; n < 9; n++) begin
      wr_reg(SRS_REG_PRESET_BASE + 4'(n - 1), 16'h0a00 + 16'(n));
    end
    wr_reg(SRS_REG_DRIVE_STATE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(SRS_REG_PRESET_INDEX, 16'(i[0]));
      op_u.set_pins(i[1], 1'b0);
      chk_sel(i[1] ? SRS_REF_AN2 : SRS_REF_AN1);
      check("source", 16'(active_source_indicator), 16'(i[1] + 1));
    end
    op_u.set_pins(1'b0, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr_reg(SRS_REG_DRIVE_STATE, 16'(s));
      repeat (4) @(posedge clk);
      #1;
      check("jog", 16'(jog_forward), 16'(s != 3));
    end
    $display("test local remote and jog done");
    op_u.set_pins(1'b1, 1'b1);
    for (int s = 0; s < 4; s++) begin
      for (int x = 1; x < 9; x++) begin
        if (s == 3 || x > 1) begin
          wr_reg(SRS_REG_SOURCE, 16'(s));
          wr_reg(SRS_REG_PRESET_INDEX, 16'(x));
          chk_sel(4'(x));
        end
      end
    end
    $display("test direct presets done");
    wr_reg(SRS_REG_PRESET_INDEX, 16'h0000);
    for (int s = 1; s < 4; s++) begin
      wr_reg(SRS_REG_SOURCE, 16'(s));
      if (s == 1) rd_chk(SRS_REG_DEST, 16'h0041);
      pulse_reset();
      rd_chk(SRS_REG_DEST, 16'h0032);
      for (int c = 0; c < 4; c++) begin
        op_u.set_pins(c[0], c[1]);
        chk_sel(c != 0 ? 4'(c + 1) :
          (s == 1 ? SRS_REF_AN1 : (s == 2 ? SRS_REF_AN2 : 4'h1)));
      end
    end
    $display("test preset code done");
    op_u.set_pins(1'b0, 1'b1);
    wr_reg(SRS_REG_DRIVE_STATE, 16'h0000);
    wr_reg(SRS_REG_SOURCE, 16'(SRS_SRC_KEYPAD));
    chk_sel(SRS_REF_KEYPAD);
    check("keypad seq", 16'(keypad_sequencer), 16'h0001);
    check("jog", 16'(jog_forward), 16'h0000);
    check("source", 16'(active_source_indicator), 16'h0004);
    wr_reg(SRS_REG_SOURCE, 16'(SRS_SRC_PRECISION));
    chk_sel(SRS_REF_PRECISION);
    check("source", 16'(active_source_indicator), 16'h0005);
    $display("test keypad and precision done");
    wr_reg(SRS_REG_SOURCE, 16'h0006);
    rd_chk(SRS_REG_SOURCE, 16'h0005);
    wr_reg(SRS_REG_PRESET_INDEX, 16'h000a);
    rd_chk(SRS_REG_PRESET_INDEX, 16'h0000);
    rd_chk(4'h7, 16'h0000);
    wr_reg(SRS_REG_DEST, 16'h0012);
    rd_chk(SRS_REG_DEST, 16'h0032);
    wr_reg(SRS_REG_AUTOSETUP_INHIBIT, 16'h0001);
    rd_chk(SRS_REG_AUTOSETUP_INHIBIT, 16'h0001);
    wr_reg(SRS_REG_DEST, 16'h0012);
    rd_chk(SRS_REG_DEST, 16'h0012);
    pulse_reset();
    rd_chk(SRS_REG_DEST, 16'h0012);
    wr_reg(SRS_REG_AUTOSETUP_INHIBIT, 16'h0000);
    pulse_reset();
    rd_chk(SRS_REG_DEST, 16'h0000);
    $display("test refusals done");
    op_u.set_pins(1'b0, 1'b0);
    wr_reg(SRS_REG_SOURCE, 16'(SRS_SRC_TWO_ANALOG));
    wr_reg(SRS_REG_SCAN_INTERVAL, 16'(SCAN));
    rd_chk(SRS_REG_SCAN_INTERVAL, 16'(SCAN));
    wr_reg(SRS_REG_PRESET_INDEX, 16'(SRS_PRESET_SCAN));
    w = 0;
    while (ref_sel !== 4'h2 && w < 400) begin
      @(posedge clk);
      #1;
      w++;
    end
    for (int k = 0; k < 8; k++) begin
      repeat (SCAN * TICK) @(posedge clk);
      #1;
      check("scan step", 16'(ref_sel),
        16'(k < 6 ? 4'(k + 3) : (k == 6 ? SRS_REF_AN1 : 4'h2)));
    end
    // Preset-only scan puts preset 1 at the base position, seven steps on.
    wr_reg(SRS_REG_SOURCE, 16'(SRS_SRC_PRESET_ONLY));
    repeat (SCAN * TICK * 7 - 2) @(posedge clk);
    #1;
    check("scan base", 16'(ref_sel), 16'h0001);
    check("scan ref", speed_ref, ref_val(4'h1));
    $display("test scan done");
    stop_test();
  end
endmodule : srs_selector_test
